// ---- logic/stopwatch_pkg.sv ----
// Shared constants and types for the stopwatch control and status block
package stopwatch_pkg;

  // ****************************************************************
  // Register indices (byte address is four times the index)
  // ****************************************************************
  localparam logic [15:0] IDX_DIR_CTL    = 16'hFF78; // Direct input enable
  localparam logic [15:0] IDX_RUN_STATUS = 16'hFF79; // Run, clear, status
  localparam logic [15:0] IDX_MS_DIGIT   = 16'hFF7A; // Capture 1/1000 s
  localparam logic [15:0] IDX_HUND_DIGIT = 16'hFF7B; // Capture 1/100 s
  localparam logic [15:0] IDX_TENTHS     = 16'hFF7C; // Capture 1/10 s
  localparam logic [15:0] IDX_IRQ_MASK   = 16'hFFE6; // Interrupt masks
  localparam logic [15:0] IDX_IRQ_FLAGS  = 16'hFFF6; // Interrupt factors
  localparam int          ADDR_W         = 18;       // Covers 4 * 0xFFFF

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int CLEAR_BIT   = 0; // Counter clear strobe, write only
  localparam int RUN_BIT     = 1; // Count run control
  localparam int RENEW_BIT   = 2; // Capture renewed flag
  localparam int CARRY_BIT   = 3; // Lap carry request flag
  localparam int DIR_EN_BIT  = 3; // Direct key input enable

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [3:0] MASK_RESET  = 4'h0;
  localparam logic [3:0] FLAG_RESET  = 4'h0;
  localparam logic [3:0] DIGIT_RESET = 4'h0;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS   = 20;        // REF_CLK at 50 MHz
  localparam int CLK_HZ          = 50000000;
  localparam int TICK_NS         = 1000000;   // Millisecond count step
  localparam int TICK_CYCLES_DEF = TICK_NS / CLK_PERIOD_NS;
  localparam int SYNC_HZ         = 1024;      // Enable switch-over rate
  localparam int SYNC_CYCLES_DEF = CLK_HZ / SYNC_HZ;

  // ****************************************************************
  // Bus answers
  // ****************************************************************
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Three BCD digits of the counter or the capture buffer
  typedef struct packed {
    logic [3:0] tenths_digit;
    logic [3:0] hundredths_digit;
    logic [3:0] millisecond_digit;
  } bcd_time_t;

  // Interrupt bits, D3 down to D0 in the mask and flag registers
  typedef struct packed {
    logic run;
    logic lap;
    logic one_hz;
    logic ten_hz;
  } irq_bits_t;

endpackage

// ---- logic/stopwatch_control.sv ----
// Stopwatch counter with run control, capture buffer and interrupt flags
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/1ps

// How it works
// - Writing one to clear strobe clears counter
// - Clear restarts if running, holds if stopped
// - Clear leaves capture buffer untouched
// - Run bit starts and stops, value kept
// - Run writes ignored while direct input active
// - Run bit reads actual counting state
// - Hold entry copies one hertz flag to carry
// - Carry flag renewed on every hold entry
// - Carry flag meaningless without direct input
// - Tenths read after renewal sets renewed flag
// - Renewed flag updated per tenths read only
// - Four readable interrupt mask bits
// - Factor flags set even when masked
// - Factor flags cleared only by writing one
// - Control bits, masks, flags reset to zero
// - Millisecond digit read triggers hold
// - Direct enable switches on 1024 Hz edge
module stopwatch_control
  import stopwatch_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF,
  parameter int unsigned SYNC_CYCLES = SYNC_CYCLES_DEF
) (
  input  wire logic              REF_CLK,
  input  wire logic              SYS_RST,
  input  wire logic [ADDR_W-1:0] AWADDR,
  input  wire logic              AWVALID,
  output logic                   AWREADY,
  input  wire logic [31:0]       WDATA,
  input  wire logic [3:0]        WSTRB,
  input  wire logic              WVALID,
  output logic                   WREADY,
  output logic [1:0]             BRESP,
  output logic                   BVALID,
  input  wire logic              BREADY,
  input  wire logic [ADDR_W-1:0] ARADDR,
  input  wire logic              ARVALID,
  output logic                   ARREADY,
  output logic [31:0]            RDATA,
  output logic [1:0]             RRESP,
  output logic                   RVALID,
  input  wire logic              RREADY,
  input  wire logic              RUN_KEY,
  input  wire logic              LAP_KEY,
  output logic                   IRQ
);

  localparam int TW = $clog2(TICK_CYCLES + 1);
  localparam int SW = $clog2(SYNC_CYCLES + 1);

  // ****************************************************************
  // Elaboration check
  // ****************************************************************
  if (TICK_CYCLES < 1 || SYNC_CYCLES < 2) begin : g_bad_param
    $error("stopwatch_control: tick or sync count too small");
  end

  // BCD step: returns carry and next digit
  function automatic logic [4:0] bcd_inc(input logic [3:0] d,
                                         input logic       en);
    if (!en) begin
      bcd_inc = {1'b0, d};
    end else if (d == 4'h9) begin
      bcd_inc = {1'b1, 4'h0};
    end else begin
      bcd_inc = {1'b0, d + 4'h1};
    end
  endfunction

  // ****************************************************************
  // State
  // ****************************************************************
  logic [TW-1:0]     tick_cnt;     // Cycles within one millisecond
  logic [SW-1:0]     sync_cnt;     // Free divider for 1024 Hz edge
  bcd_time_t         count;        // Live counter
  bcd_time_t         capture;      // Capture buffer seen by software
  logic              running;      // Actual counting state
  logic              hold;         // Capture buffer frozen
  logic              renew_pend;   // Lap renewed unread held data
  logic              carry_req;    // Lap carry request flag
  logic              renewed;      // Capture renewed flag
  logic              dir_written;  // Direct enable as written
  logic              dir_active;   // Direct enable in force
  irq_bits_t         mask;         // Interrupt enables
  irq_bits_t         flags;        // Interrupt factors
  logic              run_prev;     // Key history for edges
  logic              lap_prev;
  logic [ADDR_W-1:0] wr_addr;      // Held write address
  logic [31:0]       wr_data;      // Held write data
  logic [3:0]        wr_strb;
  logic              aw_ready;
  logic              w_ready;
  logic              b_valid;
  logic [1:0]        b_resp;
  logic              ar_ready;
  logic              r_valid;
  logic [31:0]       r_data;
  logic [1:0]        r_resp;
  logic              irq_out;

  logic [TW-1:0]     next_tick_cnt;
  logic [SW-1:0]     next_sync_cnt;
  bcd_time_t         next_count;
  bcd_time_t         next_capture;
  logic              next_running;
  logic              next_hold;
  logic              next_renew_pend;
  logic              next_carry_req;
  logic              next_renewed;
  logic              next_dir_written;
  logic              next_dir_active;
  irq_bits_t         next_mask;
  irq_bits_t         next_flags;
  logic [ADDR_W-1:0] next_wr_addr;
  logic [31:0]       next_wr_data;
  logic [3:0]        next_wr_strb;
  logic              next_aw_ready;
  logic              next_w_ready;
  logic              next_b_valid;
  logic [1:0]        next_b_resp;
  logic              next_ar_ready;
  logic              next_r_valid;
  logic [31:0]       next_r_data;
  logic [1:0]        next_r_resp;

  // Working values of the combinational process
  logic [4:0]  ms_step;
  logic [4:0]  hu_step;
  logic [4:0]  te_step;
  logic        tick;
  logic        run_edge;
  logic        lap_edge;
  logic        wr_go;
  logic        wr_lane;
  logic [15:0] wr_idx;
  logic [15:0] rd_idx;
  logic [3:0]  nib;
  irq_bits_t   set_bits;
  irq_bits_t   clr_bits;

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    next_tick_cnt    = tick_cnt;
    next_sync_cnt    = sync_cnt;
    next_count       = count;
    next_capture     = capture;
    next_running     = running;
    next_hold        = hold;
    next_renew_pend  = renew_pend;
    next_carry_req   = carry_req;
    next_renewed     = renewed;
    next_dir_written = dir_written;
    next_dir_active  = dir_active;
    next_mask        = mask;
    next_wr_addr     = wr_addr;
    next_wr_data     = wr_data;
    next_wr_strb     = wr_strb;
    next_aw_ready    = aw_ready;
    next_w_ready     = w_ready;
    next_b_valid     = b_valid;
    next_b_resp      = b_resp;
    next_ar_ready    = ar_ready;
    next_r_valid     = r_valid;
    next_r_data      = r_data;
    next_r_resp      = r_resp;
    set_bits         = '0;
    clr_bits         = '0;
    nib              = 4'h0;
    run_edge         = RUN_KEY && !run_prev;
    lap_edge         = LAP_KEY && !lap_prev;

    // Millisecond tick only while running
    tick = running && (tick_cnt == TW'(TICK_CYCLES - 1));
    if (running) begin
      next_tick_cnt = tick ? '0 : tick_cnt + TW'(1);
    end
    ms_step = bcd_inc(count.millisecond_digit, tick);
    hu_step = bcd_inc(count.hundredths_digit, ms_step[4]);
    te_step = bcd_inc(count.tenths_digit, hu_step[4]);
    next_count = {te_step[3:0], hu_step[3:0], ms_step[3:0]};
    set_bits.ten_hz = hu_step[4];
    set_bits.one_hz = te_step[4];

    // Direct enable only switches at the 1024 Hz divider edge
    if (sync_cnt == SW'(SYNC_CYCLES - 1)) begin
      next_sync_cnt   = '0;
      next_dir_active = dir_written;
    end else begin
      next_sync_cnt = sync_cnt + SW'(1);
    end

    // Unheld buffer simply follows the counter
    if (!hold) begin
      next_capture = count;
    end

    // Direct run key toggles counting
    if (dir_active && run_edge) begin
      next_running = !running;
      set_bits.run = 1'b1;
    end

    // ****************************************************************
    // Write channel: address and data taken in either order
    // ****************************************************************
    if (AWVALID && aw_ready) begin
      next_wr_addr  = AWADDR;
      next_aw_ready = 1'b0;
    end
    if (WVALID && w_ready) begin
      next_wr_data = WDATA;
      next_wr_strb = WSTRB;
      next_w_ready = 1'b0;
    end
    wr_go   = !aw_ready && !w_ready && !b_valid;
    wr_idx  = wr_addr[ADDR_W-1:2];
    wr_lane = wr_strb[0];
    if (wr_go) begin
      next_b_valid = 1'b1;
      next_b_resp  = RESP_OKAY;
      if (wr_idx == IDX_DIR_CTL) begin
        if (wr_lane) begin
          next_dir_written = wr_data[DIR_EN_BIT];
        end
      end else if (wr_idx == IDX_RUN_STATUS) begin
        // Renewed and carry bits ignore writes
        if (wr_lane && !dir_active) begin
          next_running = wr_data[RUN_BIT];
        end
        if (wr_lane && wr_data[CLEAR_BIT]) begin
          // Capture buffer is left alone here
          next_count    = '0;
          next_tick_cnt = '0;
        end
      end else if (wr_idx == IDX_IRQ_MASK) begin
        if (wr_lane) begin
          next_mask = irq_bits_t'(wr_data[3:0]);
        end
      end else if (wr_idx == IDX_IRQ_FLAGS) begin
        if (wr_lane) begin
          clr_bits = irq_bits_t'(wr_data[3:0]);
        end
      end else if (wr_idx == IDX_MS_DIGIT || wr_idx == IDX_HUND_DIGIT ||
                   wr_idx == IDX_TENTHS) begin
        next_b_resp = RESP_OKAY; // Read-only digits drop the write
      end else begin
        next_b_resp = RESP_SLVERR;
      end
    end
    if (b_valid && BREADY) begin
      next_b_valid  = 1'b0;
      next_aw_ready = 1'b1;
      next_w_ready  = 1'b1;
    end

    // ****************************************************************
    // Read channel with its side effects on the capture buffer
    // ****************************************************************
    rd_idx = ARADDR[ADDR_W-1:2];
    if (ARVALID && ar_ready) begin
      next_ar_ready = 1'b0;
      next_r_valid  = 1'b1;
      next_r_resp   = RESP_OKAY;
      if (rd_idx == IDX_DIR_CTL) begin
        nib[DIR_EN_BIT] = dir_written;
      end else if (rd_idx == IDX_RUN_STATUS) begin
        nib[RUN_BIT]   = running;
        nib[RENEW_BIT] = renewed;
        nib[CARRY_BIT] = carry_req;
      end else if (rd_idx == IDX_MS_DIGIT) begin
        if (!hold) begin
          // Freezing here stops digits rolling between reads
          next_capture   = count;
          next_hold      = 1'b1;
          next_carry_req = flags.one_hz;
          nib            = count.millisecond_digit;
        end else begin
          nib = capture.millisecond_digit;
        end
      end else if (rd_idx == IDX_HUND_DIGIT) begin
        nib = capture.hundredths_digit;
      end else if (rd_idx == IDX_TENTHS) begin
        nib          = capture.tenths_digit;
        next_renewed = renew_pend;
        next_hold    = renew_pend;
        next_renew_pend = 1'b0;
      end else if (rd_idx == IDX_IRQ_MASK) begin
        nib = mask;
      end else if (rd_idx == IDX_IRQ_FLAGS) begin
        nib = flags;
      end else begin
        next_r_resp = RESP_SLVERR;
      end
      next_r_data = {28'h0, nib};
    end
    if (r_valid && RREADY) begin
      next_r_valid  = 1'b0;
      next_ar_ready = 1'b1;
    end

    // Lap key captures last so it wins over a read in the same cycle
    if (dir_active && lap_edge) begin
      next_capture    = count;
      next_renew_pend = hold || next_renew_pend;
      next_hold       = 1'b1;
      next_carry_req  = flags.one_hz;
      set_bits.lap    = 1'b1;
    end

    // A set in the clearing cycle survives
    next_flags = (flags & ~clr_bits) | set_bits;
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      tick_cnt    <= '0;
      sync_cnt    <= '0;
      count       <= {DIGIT_RESET, DIGIT_RESET, DIGIT_RESET};
      capture     <= {DIGIT_RESET, DIGIT_RESET, DIGIT_RESET};
      running     <= 1'b0;
      hold        <= 1'b0;
      renew_pend  <= 1'b0;
      carry_req   <= 1'b0;
      renewed     <= 1'b0;
      dir_written <= 1'b0;
      dir_active  <= 1'b0;
      mask        <= MASK_RESET;
      flags       <= FLAG_RESET;
      run_prev    <= 1'b0;
      lap_prev    <= 1'b0;
      wr_addr     <= '0;
      wr_data     <= 32'h0;
      wr_strb     <= 4'h0;
      aw_ready    <= 1'b1;
      w_ready     <= 1'b1;
      b_valid     <= 1'b0;
      b_resp      <= RESP_OKAY;
      ar_ready    <= 1'b1;
      r_valid     <= 1'b0;
      r_data      <= 32'h0;
      r_resp      <= RESP_OKAY;
      irq_out     <= 1'b0;
    end else begin
      tick_cnt    <= next_tick_cnt;
      sync_cnt    <= next_sync_cnt;
      count       <= next_count;
      capture     <= next_capture;
      running     <= next_running;
      hold        <= next_hold;
      renew_pend  <= next_renew_pend;
      carry_req   <= next_carry_req;
      renewed     <= next_renewed;
      dir_written <= next_dir_written;
      dir_active  <= next_dir_active;
      mask        <= next_mask;
      flags       <= next_flags;
      run_prev    <= RUN_KEY;
      lap_prev    <= LAP_KEY;
      wr_addr     <= next_wr_addr;
      wr_data     <= next_wr_data;
      wr_strb     <= next_wr_strb;
      aw_ready    <= next_aw_ready;
      w_ready     <= next_w_ready;
      b_valid     <= next_b_valid;
      b_resp      <= next_b_resp;
      ar_ready    <= next_ar_ready;
      r_valid     <= next_r_valid;
      r_data      <= next_r_data;
      r_resp      <= next_r_resp;
      irq_out     <= |(next_flags & next_mask);
    end
  end

  // Ports straight from flip-flops
  assign AWREADY = aw_ready;
  assign WREADY  = w_ready;
  assign BVALID  = b_valid;
  assign BRESP   = b_resp;
  assign ARREADY = ar_ready;
  assign RVALID  = r_valid;
  assign RDATA   = r_data;
  assign RRESP   = r_resp;
  assign IRQ     = irq_out;

endmodule

// ---- tb/stopwatch_control_asserts.sv ----
// Bus and interrupt checks bound to the stopwatch control block
`timescale 1ns/1ps
module stopwatch_control_asserts
  import stopwatch_pkg::*;
(
  input wire logic              REF_CLK,
  input wire logic              SYS_RST,
  input wire logic [ADDR_W-1:0] AWADDR,
  input wire logic              AWVALID,
  input wire logic              AWREADY,
  input wire logic [31:0]       WDATA,
  input wire logic [3:0]        WSTRB,
  input wire logic              WVALID,
  input wire logic              WREADY,
  input wire logic [1:0]        BRESP,
  input wire logic              BVALID,
  input wire logic              BREADY,
  input wire logic [ADDR_W-1:0] ARADDR,
  input wire logic              ARVALID,
  input wire logic              ARREADY,
  input wire logic [31:0]       RDATA,
  input wire logic [1:0]        RRESP,
  input wire logic              RVALID,
  input wire logic              RREADY,
  input wire logic              RUN_KEY,
  input wire logic              LAP_KEY,
  input wire logic              IRQ
);
  // ****************************************************************
  // Shadow of the mask register, rebuilt from bus traffic
  // ****************************************************************
  logic [15:0] aw_idx;      // Index of the write in flight
  logic [3:0]  w_nib;       // Low nibble of its data
  logic        b_seen;      // Last BVALID
  logic [3:0]  mask_sh;     // Mask as written
  logic [15:0] next_aw_idx;
  logic [3:0]  next_w_nib;
  logic [3:0]  next_mask_sh;
  logic        ar_take;     // Read taken
  logic        ar_mapped;   // Read hits a register

  assign ar_take   = ARVALID && ARREADY;
  assign ar_mapped = ARADDR[17:2] inside {IDX_DIR_CTL, IDX_RUN_STATUS,
    IDX_MS_DIGIT, IDX_HUND_DIGIT, IDX_TENTHS, IDX_IRQ_MASK, IDX_IRQ_FLAGS};

  // Commit lags the block by one edge
  always_comb begin
    next_aw_idx  = aw_idx;
    next_w_nib   = w_nib;
    next_mask_sh = mask_sh;
    if (AWVALID && AWREADY) begin
      next_aw_idx = AWADDR[17:2];
    end
    if (WVALID && WREADY && WSTRB[0]) begin
      next_w_nib = WDATA[3:0];
    end
    if (BVALID && !b_seen && aw_idx == IDX_IRQ_MASK) begin
      next_mask_sh = w_nib;
    end
  end

  // Registers only
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      aw_idx  <= 16'h0000;
      w_nib   <= 4'h0;
      b_seen  <= 1'b0;
      mask_sh <= MASK_RESET;
    end else begin
      aw_idx  <= next_aw_idx;
      w_nib   <= next_w_nib;
      b_seen  <= BVALID;
      mask_sh <= next_mask_sh;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_rvalid_next: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    ar_take |=> RVALID && !ARREADY) else $error("read answer late");
  a_rdata_hold: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    RVALID && !RREADY |=> RVALID && $stable(RDATA))
    else $error("R not held");
  a_bvalid_hold: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    BVALID && !BREADY |=> BVALID && $stable(BRESP))
    else $error("B not held");
  a_b_after_both: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    AWVALID && AWREADY && WVALID && WREADY |=> !AWREADY ##1 BVALID)
    else $error("B timing wrong");
  a_rdata_upper: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    RVALID |-> RDATA[31:4] == 28'h0) else $error("upper read bits set");
  a_clear_reads_zero: assert property (
    @(posedge REF_CLK) disable iff (SYS_RST)
    ar_take && ARADDR[17:2] == IDX_RUN_STATUS |=> RDATA[CLEAR_BIT] == 1'b0)
    else $error("clear strobe read as one");
  a_unmapped_err: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    ar_take && !ar_mapped |=> RRESP == RESP_SLVERR)
    else $error("unmapped read accepted");
  a_mask_readback: assert property (
    @(posedge REF_CLK) disable iff (SYS_RST)
    ar_take && ARADDR[17:2] == IDX_IRQ_MASK |=> RDATA[3:0] == mask_sh)
    else $error("mask readback wrong");
  a_irq_masked: assert property (
    @(posedge REF_CLK) disable iff (SYS_RST)
    mask_sh == 4'h0 && $past(mask_sh) == 4'h0 && !BVALID |-> !IRQ)
    else $error("masked interrupt raised");
endmodule

bind stopwatch_control stopwatch_control_asserts u_chk (
  .REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .AWADDR(AWADDR),
  .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB),
  .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
  .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
  .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
  .RREADY(RREADY), .RUN_KEY(RUN_KEY), .LAP_KEY(LAP_KEY), .IRQ(IRQ));

// ---- tb/tb.sv ----
// Bench for the stopwatch control block
`timescale 1ns/1ps
module tb;
  import stopwatch_pkg::*;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic              REF_CLK = 1'b0;
  logic              SYS_RST = 1'b1;
  logic [ADDR_W-1:0] AWADDR  = '0;
  logic              AWVALID = 1'b0;
  logic              AWREADY;
  logic [31:0]       WDATA   = '0;
  logic [3:0]        WSTRB   = 4'hF;
  logic              WVALID  = 1'b0;
  logic              WREADY;
  logic [1:0]        BRESP;
  logic              BVALID;
  logic              BREADY  = 1'b0;
  logic [ADDR_W-1:0] ARADDR  = '0;
  logic              ARVALID = 1'b0;
  logic              ARREADY;
  logic [31:0]       RDATA;
  logic [1:0]        RRESP;
  logic              RVALID;
  logic              RREADY  = 1'b0;
  logic              RUN_KEY = 1'b0;
  logic              LAP_KEY = 1'b0;
  logic              IRQ;
  int                num_errors = 0; // Mismatches
  int                compares   = 0; // Comparisons made
  int                cycles     = 0; // Watchdog count
  logic [31:0]       rd;             // Last read data
  logic [1:0]        rr;             // Last read response
  logic [11:0]       t0;             // Time before a pause
  logic [11:0]       t1;             // Time after it

  // Short counts keep the run brief
  stopwatch_control #(.TICK_CYCLES(4), .SYNC_CYCLES(8)) dut (
    .REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .AWADDR(AWADDR),
    .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB),
    .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
    .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
    .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
    .RREADY(RREADY), .RUN_KEY(RUN_KEY), .LAP_KEY(LAP_KEY), .IRQ(IRQ));

  initial forever #10 REF_CLK = ~REF_CLK;

  // Hang guard, well above the run's length
  always @(posedge REF_CLK) begin
    cycles++;
    if (cycles == 15000) begin
      num_errors++;
      end_of_test();
    end
  end

  // ****************************************************************
  // Bus and key tasks
  // ****************************************************************
  task automatic check(string name, logic [31:0] exp, logic [31:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(logic [15:0] idx, logic [3:0] d);
    @(posedge REF_CLK);
    AWADDR  <= {idx, 2'b00};
    AWVALID <= 1'b1;
    WDATA   <= {28'h0, d};
    WVALID  <= 1'b1;
    BREADY  <= 1'b1;
    do begin
      @(posedge REF_CLK);
      if (AWREADY) begin
        AWVALID <= 1'b0;
      end
      if (WREADY) begin
        WVALID <= 1'b0;
      end
    end while (!BVALID);
    BREADY <= 1'b0;
    check("write response", {30'h0, RESP_OKAY}, {30'h0, BRESP});
  endtask

  task automatic rd_reg(logic [15:0] idx);
    @(posedge REF_CLK);
    ARADDR  <= {idx, 2'b00};
    ARVALID <= 1'b1;
    RREADY  <= 1'b1;
    do @(posedge REF_CLK); while (!ARREADY);
    ARVALID <= 1'b0;
    do @(posedge REF_CLK); while (!RVALID);
    rd = RDATA;
    rr = RRESP;
    RREADY <= 1'b0;
  endtask

  task automatic rchk(string n, logic [15:0] idx, logic [3:0] m,
                      logic [3:0] e);
    rd_reg(idx);
    check(n, {28'h0, e}, rd & {28'h0, m});
  endtask

  // Digits in fixed order, lowest first
  task automatic read_time(output logic [11:0] t);
    rd_reg(IDX_MS_DIGIT);
    t[3:0] = rd[3:0];
    rd_reg(IDX_HUND_DIGIT);
    t[7:4] = rd[3:0];
    rd_reg(IDX_TENTHS);
    t[11:8] = rd[3:0];
  endtask

  task automatic press(bit run_key);
    @(posedge REF_CLK);
    if (run_key) begin
      RUN_KEY <= 1'b1;
    end else begin
      LAP_KEY <= 1'b1;
    end
    repeat (3) @(posedge REF_CLK);
    RUN_KEY <= 1'b0;
    LAP_KEY <= 1'b0;
    repeat (3) @(posedge REF_CLK);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    rchk("run status", IDX_RUN_STATUS, 4'hF, 4'h0);
    rchk("mask", IDX_IRQ_MASK, 4'hF, MASK_RESET);
    rchk("flags", IDX_IRQ_FLAGS, 4'hF, FLAG_RESET);
    read_time(t0);
    check("time", 32'h0, {20'h0, t0});
    rd_reg(16'h0010);
    check("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, rr});
  endtask

  task automatic t_run_stop();
    wr(IDX_RUN_STATUS, 4'h2);
    rchk("running", IDX_RUN_STATUS, 4'hF, 4'h2);
    repeat (40) @(posedge REF_CLK);
    wr(IDX_RUN_STATUS, 4'h0);
    rchk("stopped", IDX_RUN_STATUS, 4'hF, 4'h0);
    read_time(t0);
    repeat (40) @(posedge REF_CLK);
    read_time(t1);
    check("stopped time", {20'h0, t0}, {20'h0, t1});
    wr(IDX_RUN_STATUS, 4'h2);
    repeat (40) @(posedge REF_CLK);
    read_time(t1);
    check("resumed", 32'h1, {31'h0, t1 > t0});
  endtask

  // Capture frozen near 150 ms
  task automatic t_clear();
    repeat (500) @(posedge REF_CLK);
    rd_reg(IDX_MS_DIGIT);
    wr(IDX_RUN_STATUS, 4'h3);
    read_time(t1);
    check("held tenths", 32'h1, {31'h0, t1[11:8] != 4'h0});
    check("held time", 32'h1, {31'h0, t1 >= 12'h120});
    rchk("still running", IDX_RUN_STATUS, 4'hF, 4'h2);
    repeat (16) @(posedge REF_CLK);
    read_time(t0);
    check("restart", 32'h1, {31'h0, t0 != 0 && t0 < 12'h020});
    wr(IDX_RUN_STATUS, 4'h0);
    wr(IDX_RUN_STATUS, 4'h1);
    repeat (20) @(posedge REF_CLK);
    read_time(t0);
    check("cleared held", 32'h0, {20'h0, t0});
  endtask

  task automatic t_flags_direct();
    wr(IDX_RUN_STATUS, 4'h3);
    wr(IDX_IRQ_FLAGS, 4'hF);
    repeat (4100) @(posedge REF_CLK);
    rchk("timed flags", IDX_IRQ_FLAGS, 4'hF, 4'h3);
    check("irq masked", 32'h0, {31'h0, IRQ});
    wr(IDX_IRQ_FLAGS, 4'h0);
    rchk("zero write", IDX_IRQ_FLAGS, 4'hF, 4'h3);
    wr(IDX_IRQ_MASK, 4'h1);
    rchk("mask", IDX_IRQ_MASK, 4'hF, 4'h1);
    repeat (2) @(posedge REF_CLK);
    check("irq on", 32'h1, {31'h0, IRQ});
    wr(IDX_DIR_CTL, 4'h8);
    repeat (20) @(posedge REF_CLK);
    rchk("direct ctl", IDX_DIR_CTL, 4'hF, 4'h8);
    press(1'b0);
    rchk("carry set", IDX_RUN_STATUS, 4'hF, 4'hA);
    wr(IDX_IRQ_FLAGS, 4'h2);
    rchk("one hz clear", IDX_IRQ_FLAGS, 4'h2, 4'h0);
    press(1'b0);
    rd_reg(IDX_TENTHS);
    rchk("renewed", IDX_RUN_STATUS, 4'h4, 4'h4);
    wr(IDX_RUN_STATUS, 4'h0);
    rchk("write ignored", IDX_RUN_STATUS, 4'h6, 4'h6);
    press(1'b1);
    rchk("key stop", IDX_RUN_STATUS, 4'h2, 4'h0);
    rchk("key flags", IDX_IRQ_FLAGS, 4'hC, 4'hC);
    wr(IDX_IRQ_FLAGS, 4'hF);
    rchk("all clear", IDX_IRQ_FLAGS, 4'hF, 4'h0);
    repeat (2) @(posedge REF_CLK);
    check("irq off", 32'h0, {31'h0, IRQ});
    wr(IDX_DIR_CTL, 4'h0);
    repeat (20) @(posedge REF_CLK);
    wr(IDX_RUN_STATUS, 4'h2);
    rchk("soft run", IDX_RUN_STATUS, 4'h2, 4'h2);
  endtask

  // ****************************************************************
  // Main sequence and verdict
  // ****************************************************************
  task automatic end_of_test();
    if (num_errors == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge REF_CLK);
    SYS_RST <= 1'b0;
    t_reset();
    t_run_stop();
    t_clear();
    t_flags_direct();
    end_of_test();
  end
endmodule
